// ### dv/acl_l4_checker.sv
// Port-level assertions for the access rule entry matcher
`timescale 1ns/1ps
`default_nettype none
module acl_l4_checker
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [31:0] prdata,
	input wire logic        hdr_valid,
	input wire logic        hit_valid,
	input wire logic        hit
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable && pready;
	endsequence
	a_setup_gets_ready: assert property (s_setup |=> s_access)
		else $error("no ready after setup");
	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_ready_in_access: assert property (pready |-> psel && penable)
		else $error("ready outside access");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_rdata_quiet: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
		else $error("read data outside read");
	a_hit_one_later: assert property (hdr_valid |=> hit_valid)
		else $error("no result after header");
	a_no_stray_result: assert property (!hdr_valid |=> !hit_valid)
		else $error("result without header");
	a_hit_holds: assert property (!hdr_valid |=> $stable(hit))
		else $error("hit changed without header");
endmodule
`default_nettype wire

// ### dv/acl_l4_ethertype_matcher_tb.sv
// Self-checking bench for the access rule entry matcher
`timescale 1ns/1ps
`default_nettype none
`include "acl_l4_defines.vh"
module acl_l4_ethertype_matcher_tb;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
	logic        hdr_valid, frame_is_tcp, hit_valid, hit;
	logic [11:0] paddr;
	logic [3:0]  pstrb, strb;
	logic [31:0] pwdata, prdata, rdat;
	logic [15:0] frame_sport, frame_dport, frame_ethtype;
	logic [5:0]  frame_tcp_flags;
	int          err_count, total_checks, cyc;
	acl_l4_ethertype_matcher DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb, .prdata, .pready, .pslverr, .hdr_valid, .frame_is_tcp, .frame_sport,
		.frame_dport, .frame_tcp_flags, .frame_ethtype, .hit_valid, .hit);
	frame_src src (.pclk, .hdr_valid, .frame_is_tcp, .frame_sport, .frame_dport,
		.frame_tcp_flags, .frame_ethtype);
	initial
	begin
		pclk = 0;
		forever #4 pclk = ~pclk;
	end
	task finish_test;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Runaway guard, far above the few hundred cycles the tests need
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 8000)
		begin
			err_count++;
			finish_test;
		end
	end
	task chk(input string n, input logic [31:0] s, e);
		total_checks++;
		if (s !== e)
		begin
			err_count++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic xerr);
		int n;
		logic rdy;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		pstrb <= strb;
		@(posedge pclk);
		penable <= 1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rdat = prdata;
		rerr = pslverr;
		rdy = pready;
		{psel, penable} <= 2'b00;
		chk("pready", rdy, 1);
		chk("pslverr", rerr, xerr);
	endtask
	task rd(input logic [11:0] a, input logic [31:0] x);
		apb(0, a, 32'h0, 0);
		chk("prdata", rdat, x);
	endtask
	task fr(input logic t, input logic [15:0] s, d, input logic [5:0] f, input logic [15:0] e,
		input logic x);
		src.send(t, s, d, f, e);
		#1;
		chk("hit_valid", hit_valid, 1);
		chk("hit", hit, x);
	endtask
	task t_reset;
		rd(`OFS_CTRL, `RST_CTRL);
		rd(`OFS_SPORT_BOUND, `RST_BOUND);
		rd(`OFS_TCP_FLAGS, {20'h0, `RST_FLAGS});
		rd(`OFS_ETYPE, {15'h0, `RST_ETYPE});
		apb(0, 12'h040, 32'h0, 1);
		chk("unmapped", rdat, 0);
		fr(1, 0, 0, 0, 16'h0600, 0);
		$display("reset test done");
	endtask
	task t_ports;
		apb(1, `OFS_CTRL, 32'h101, 0);
		apb(1, `OFS_SPORT_MODE, 32'h1, 0);
		apb(1, `OFS_SPORT_BOUND, 32'h3e8, 0);
		fr(1, 16'h3e8, 0, 0, 0, 1);
		fr(1, 16'h3e9, 0, 0, 0, 0);
		apb(1, `OFS_SPORT_MODE, 32'h2, 0);
		apb(1, `OFS_SPORT_BOUND, 32'h0014_000a, 0);
		fr(1, 16'h000a, 0, 0, 0, 1);
		fr(1, 16'h0014, 0, 0, 0, 1);
		fr(1, 16'h0015, 0, 0, 0, 0);
		fr(1, 16'h0009, 0, 0, 0, 0);
		apb(1, `OFS_SPORT_BOUND, 32'h000a_0014, 0);
		fr(1, 16'h000f, 0, 0, 0, 0);
		apb(1, `OFS_SPORT_MODE, 32'h0, 0);
		fr(1, 16'h1234, 0, 0, 0, 1);
		apb(1, `OFS_DPORT_MODE, 32'h1, 0);
		apb(1, `OFS_DPORT_BOUND, 32'hffff, 0);
		fr(1, 0, 16'hffff, 0, 0, 1);
		fr(1, 0, 16'hfffe, 0, 0, 0);
		apb(1, `OFS_CTRL, 32'h001, 0);
		fr(1, 0, 16'hfffe, 0, 0, 1);
		apb(1, `OFS_CTRL, 32'h201, 0);
		fr(0, 0, 16'hfffe, 0, 0, 0);
		fr(0, 0, 16'hffff, 0, 0, 1);
		apb(1, `OFS_CTRL, 32'h101, 0);
		apb(1, `OFS_DPORT_MODE, 32'h2, 0);
		apb(1, `OFS_DPORT_BOUND, 32'hffff_0000, 0);
		fr(1, 0, 16'h0000, 0, 0, 1);
		apb(1, `OFS_DPORT_MODE, 32'h0, 0);
		$display("port test done");
	endtask
	task t_flags;
		logic [11:0] st;
		for (int i = 0; i < 6; i++)
		begin
			st = 12'haaa & ~(12'h3 << 2 * i);
			apb(1, `OFS_TCP_FLAGS, {20'h0, st}, 0);
			fr(1, 0, 0, 6'h1 << i, 0, 0);
			fr(1, 0, 0, 6'h0, 0, 1);
			apb(1, `OFS_TCP_FLAGS, {20'h0, st | (12'h1 << 2 * i)}, 0);
			fr(1, 0, 0, 6'h1 << i, 0, 1);
			fr(1, 0, 0, 6'h0, 0, 0);
			fr(0, 0, 0, 6'h0, 0, 1);
			apb(1, `OFS_TCP_FLAGS, {20'h0, st | (12'h2 << 2 * i)}, 0);
			fr(1, 0, 0, 6'h1 << i, 0, 1);
		end
		$display("flag test done");
	endtask
	task t_etype;
		logic [15:0] bad [3];
		bad = '{`ETYPE_IPV4, `ETYPE_ARP, `ETYPE_IPV6};
		apb(1, `OFS_CTRL, 32'h111, 0);
		apb(1, `OFS_ETYPE, 32'h1_1234, 0);
		fr(0, 0, 0, 0, 16'h1234, 1);
		fr(0, 0, 0, 0, 16'h1235, 0);
		apb(1, `OFS_CTRL, 32'h101, 0);
		fr(0, 0, 0, 0, 16'h1235, 1);
		apb(1, `OFS_CTRL, 32'h111, 0);
		apb(1, `OFS_STATUS, 32'h3, 0);
		foreach (bad[i])
			apb(1, `OFS_ETYPE, {15'h0, 1'b1, bad[i]}, 1);
		rd(`OFS_ETYPE, 32'h1_1234);
		rd(`OFS_STATUS, 32'h0000_0003);
		rd(`OFS_REJ_VALUE, {16'h0, `ETYPE_IPV6});
		apb(1, `OFS_STATUS, 32'h2, 0);
		rd(`OFS_STATUS, 32'h0000_0001);
		apb(1, `OFS_ETYPE, 32'h1_05ff, 1);
		apb(1, `OFS_ETYPE, 32'h1_0600, 0);
		fr(0, 0, 0, 0, 16'h0600, 1);
		rd(`OFS_STATUS, 32'h0001_0003);
		rd(`OFS_REJ_VALUE, 32'h0000_05ff);
		apb(1, `OFS_ETYPE, 32'h0_1234, 0);
		fr(0, 0, 0, 0, 16'h1235, 1);
		apb(1, `OFS_ETYPE, {16'h0, `ETYPE_IPV4}, 0);
		strb = 4'h4;
		apb(1, `OFS_ETYPE, 32'h0001_0000, 1);
		strb = 4'h3;
		apb(1, `OFS_ETYPE, 32'h0001_1234, 0);
		strb = 4'hf;
		rd(`OFS_ETYPE, 32'h0000_1234);
		$display("type test done");
	endtask
	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
		strb = 4'hf;
		repeat (20) @(posedge pclk);
		presetn <= 1;
		t_reset;
		t_ports;
		t_flags;
		t_etype;
		finish_test;
	end
endmodule
bind acl_l4_ethertype_matcher acl_l4_checker chk_i (.pclk, .presetn, .psel, .penable, .pwrite,
	.pready, .pslverr, .prdata, .hdr_valid, .hit_valid, .hit);
`default_nettype wire

// ### dv/frame_src.sv
// Header parser stand-in that presents one parsed frame at a time
`timescale 1ns/1ps
`default_nettype none
module frame_src
(
	input  wire logic        pclk,
	output logic             hdr_valid,
	output logic             frame_is_tcp,
	output logic [15:0]      frame_sport,
	output logic [15:0]      frame_dport,
	output logic [5:0]       frame_tcp_flags,
	output logic [15:0]      frame_ethtype
);
	initial
	begin
		hdr_valid = 0;
		{frame_is_tcp, frame_sport, frame_dport, frame_tcp_flags, frame_ethtype} = '0;
	end
	task send(input logic t, input logic [15:0] s, d, input logic [5:0] f, input logic [15:0] e);
		@(posedge pclk);
		hdr_valid <= 1;
		{frame_is_tcp, frame_sport, frame_dport, frame_tcp_flags, frame_ethtype} <= {t, s, d, f, e};
		@(posedge pclk);
		hdr_valid <= 0;
		// Stale fields are inverted so nothing relies on them lingering
		{frame_is_tcp, frame_sport, frame_dport, frame_tcp_flags, frame_ethtype} <= ~{t, s, d, f, e};
	endtask
endmodule
`default_nettype wire

// ### src/acl_l4_defines.vh
// Register offsets, field positions and reset values of the layer-4 entry matcher
`ifndef ACL_L4_DEFINES_VH
`define ACL_L4_DEFINES_VH

// Register byte offsets
`define OFS_CTRL        12'h000
`define OFS_SPORT_MODE  12'h004
`define OFS_SPORT_BOUND 12'h008
`define OFS_DPORT_MODE  12'h00c
`define OFS_DPORT_BOUND 12'h010
`define OFS_TCP_FLAGS   12'h014
`define OFS_ETYPE       12'h018
`define OFS_STATUS      12'h01c
`define OFS_REJ_VALUE   12'h020

// Control fields
`define CTRL_EN_BIT     0
`define CTRL_FTYPE_LSB  4
`define CTRL_PROTO_LSB  8

// Frame-type selection codes
`define FTYPE_ANY       2'h0
`define FTYPE_ETYPE     2'h1
`define FTYPE_ARP       2'h2
`define FTYPE_IP        2'h3

// Protocol selection codes
`define PROTO_OTHER     2'h0
`define PROTO_TCP       2'h1
`define PROTO_UDP       2'h2

// Port criterion modes
`define PMODE_ANY       2'h0
`define PMODE_SINGLE    2'h1
`define PMODE_RANGE     2'h2

// Three-valued flag setting codes, two bits per flag
`define FSET_CLEAR      2'h0
`define FSET_SET        2'h1
`define FSET_ANY        2'h2

// EtherType field
`define ETYPE_SPEC_BIT  16
`define ETYPE_MIN       16'h0600
`define ETYPE_IPV4      16'h0800
`define ETYPE_ARP       16'h0806
`define ETYPE_IPV6      16'h86dd

// Status fields
`define STAT_HIT_BIT    0
`define STAT_REJ_BIT    1
`define STAT_CNT_LSB    16

// Reset values
`define RST_CTRL        32'h0000_0000
`define RST_PMODE       2'h0
`define RST_BOUND       32'hffff_0000
`define RST_FLAGS       12'haaa
`define RST_ETYPE       17'h0_0600

`endif

// ### src/acl_l4_ethertype_matcher.v
// Access rule entry matcher for ports, TCP flags and EtherType, with APB setup
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "acl_l4_defines.vh"

// Overview of operation
// R1: Source port criterion offers don't-care, single value and range modes.
// R2: Single source value is 16 bits; hit only on equal source port.
// R3: Source range bounds are 16 bits; hit when source port inside range.
// R4: Destination port criterion offers the same three modes.
// R5: Single destination value is 16 bits; hit only on equal destination port.
// R6: Destination range bounds are 16 bits; hit when port inside range.
// R7: FIN setting: 0 rejects set flag, 1 needs it set, any ignores.
// R8: SYN setting: 0 rejects set flag, 1 needs it set, any ignores.
// R9: RST setting: 0 rejects set flag, 1 needs it set, any ignores.
// R10: PSH setting: 0 rejects set flag, 1 needs it set, any ignores.
// R11: ACK setting: 0 rejects set flag, 1 needs it set, any ignores.
// R12: URG setting: 0 rejects set flag, 1 needs it set, any ignores.
// R13: EtherType criteria count only when frame-type selection is EtherType class.
// R14: EtherType criterion is don't-care or compares one configured value.
// R15: Specific EtherType lies in 0x600..0xffff; hit only on equal type.
// R16: Writes of specific EtherType 0x800, 0x806 or 0x86dd are rejected.
// R17: Port and flag criteria apply only for TCP or UDP; flags only TCP.
// R18: Range bounds are inclusive; lower above upper never hits.
// R19: Hit needs all enabled criteria; registered one clock after header valid.
module acl_l4_ethertype_matcher
#(
	parameter ADDR_W = 12,
	parameter CNT_W  = 16
)
(
	// Clock and reset
	input  wire              pclk,
	input  wire              presetn,
	// APB slave
	input  wire              psel,
	input  wire              penable,
	input  wire              pwrite,
	input  wire [ADDR_W-1:0] paddr,
	input  wire [31:0]       pwdata,
	input  wire [3:0]        pstrb,
	output reg  [31:0]       prdata,
	output reg               pready,
	output reg               pslverr,
	// Parsed header fields
	input  wire              hdr_valid,
	input  wire              frame_is_tcp,
	input  wire [15:0]       frame_sport,
	input  wire [15:0]       frame_dport,
	input  wire [5:0]        frame_tcp_flags,
	input  wire [15:0]       frame_ethtype,
	// Match result
	output reg               hit_valid,
	output reg               hit
);

	// Configuration state
	reg  [31:0]      ctrl_q;
	reg  [1:0]       sport_mode_q;
	reg  [31:0]      sport_bound_q;
	reg  [1:0]       dport_mode_q;
	reg  [31:0]      dport_bound_q;
	reg  [11:0]      flags_q;
	reg  [16:0]      etype_q;
	reg              rej_q;
	reg  [15:0]      rej_value_q;
	reg  [CNT_W-1:0] hit_cnt_q;

	// Bus decode
	wire             setup     = psel & ~penable;
	wire             access    = psel & penable & pready;
	wire             wr_access = access & pwrite;
	wire [ADDR_W-1:0] addr     = paddr;
	reg              mapped;
	reg  [31:0]      rd_mux;
	wire [31:0]      wmask     = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

	// EtherType write check on the merged value
	wire [31:0]      etype_wr  = ({15'h0000, etype_q} & ~wmask) | (pwdata & wmask);
	wire             etype_bad = etype_wr[`ETYPE_SPEC_BIT] &&
	                             ((etype_wr[15:0] < `ETYPE_MIN) ||
	                              (etype_wr[15:0] == `ETYPE_IPV4) ||
	                              (etype_wr[15:0] == `ETYPE_ARP) ||
	                              (etype_wr[15:0] == `ETYPE_IPV6));
	wire             addr_etype = (addr == `OFS_ETYPE);

	always @*
	begin
		mapped = 1'b1;
		rd_mux = 32'h0000_0000;
		case (addr)
			`OFS_CTRL:        rd_mux = ctrl_q;
			`OFS_SPORT_MODE:  rd_mux = {30'h0000_0000, sport_mode_q};
			`OFS_SPORT_BOUND: rd_mux = sport_bound_q;
			`OFS_DPORT_MODE:  rd_mux = {30'h0000_0000, dport_mode_q};
			`OFS_DPORT_BOUND: rd_mux = dport_bound_q;
			`OFS_TCP_FLAGS:   rd_mux = {20'h00000, flags_q};
			`OFS_ETYPE:       rd_mux = {15'h0000, etype_q};
			`OFS_STATUS:      rd_mux = {hit_cnt_q, 14'h0000, rej_q, hit};
			`OFS_REJ_VALUE:   rd_mux = {16'h0000, rej_value_q};
			default:          mapped = 1'b0;
		endcase
	end

	// Answer prepared in the setup cycle so the access phase ends at its first edge
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
		else
		begin
			pready  <= setup;
			pslverr <= setup & (~mapped | (pwrite & addr_etype & etype_bad)); // see R16
			prdata  <= (setup & ~pwrite) ? rd_mux : 32'h0000_0000;
		end
	end

	// Write strobes, each taken at the access edge only
	wire        we_ctrl        = wr_access & (addr == `OFS_CTRL);
	wire        we_sport_mode  = wr_access & (addr == `OFS_SPORT_MODE) & pstrb[0];
	wire        we_sport_bound = wr_access & (addr == `OFS_SPORT_BOUND);
	wire        we_dport_mode  = wr_access & (addr == `OFS_DPORT_MODE) & pstrb[0];
	wire        we_dport_bound = wr_access & (addr == `OFS_DPORT_BOUND);
	wire        we_flags       = wr_access & (addr == `OFS_TCP_FLAGS);
	wire        we_etype       = wr_access & addr_etype;
	wire        we_status      = wr_access & (addr == `OFS_STATUS) & pstrb[0];

	// Byte lanes not enabled keep their stored bits
	wire [31:0] ctrl_d         = (ctrl_q & ~wmask) | (pwdata & wmask);
	wire [31:0] sport_bound_d  = (sport_bound_q & ~wmask) | (pwdata & wmask);
	wire [31:0] dport_bound_d  = (dport_bound_q & ~wmask) | (pwdata & wmask);
	wire [11:0] flags_d        = (flags_q & ~wmask[11:0]) | (pwdata[11:0] & wmask[11:0]);

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_q <= `RST_CTRL;
		end
		else if (we_ctrl)
		begin
			ctrl_q <= ctrl_d;
		end
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sport_mode_q <= `RST_PMODE;
		end
		else if (we_sport_mode)
		begin
			sport_mode_q <= pwdata[1:0]; // see R1
		end
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sport_bound_q <= `RST_BOUND;
		end
		else if (we_sport_bound)
		begin
			sport_bound_q <= sport_bound_d;
		end
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			dport_mode_q <= `RST_PMODE;
		end
		else if (we_dport_mode)
		begin
			dport_mode_q <= pwdata[1:0]; // see R4
		end
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			dport_bound_q <= `RST_BOUND;
		end
		else if (we_dport_bound)
		begin
			dport_bound_q <= dport_bound_d;
		end
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			flags_q <= `RST_FLAGS;
		end
		else if (we_flags)
		begin
			flags_q <= flags_d;
		end
	end

	// Bad value leaves the old setting in force
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			etype_q     <= `RST_ETYPE;
			rej_value_q <= 16'h0000;
		end
		else if (we_etype)
		begin
			if (etype_bad)
				rej_value_q <= etype_wr[15:0]; // see R16
			else
				etype_q <= etype_wr[16:0]; // see R15
		end
	end

	// Sticky reject flag, write one to clear; a new reject wins over the clear
	wire rej_set = we_etype & etype_bad;
	wire rej_clr = we_status & pwdata[`STAT_REJ_BIT];

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rej_q <= 1'b0;
		else if (rej_set)
			rej_q <= 1'b1; // see R16
		else if (rej_clr)
			rej_q <= 1'b0;
	end

	// Criterion evaluation
	wire [1:0] ftype_sel = ctrl_q[`CTRL_FTYPE_LSB+1:`CTRL_FTYPE_LSB];
	wire [1:0] proto_sel = ctrl_q[`CTRL_PROTO_LSB+1:`CTRL_PROTO_LSB];
	wire       entry_en  = ctrl_q[`CTRL_EN_BIT];
	wire       l4_sel    = (proto_sel == `PROTO_TCP) || (proto_sel == `PROTO_UDP);
	wire       sport_ok;
	wire       dport_ok;
	wire       flags_ok;

	port_match u_sport
	(
		.mode  (sport_mode_q),
		.lo    (sport_bound_q[15:0]),
		.hi    (sport_bound_q[31:16]),
		.port  (frame_sport),
		.match (sport_ok)
	); // see R2, R3, R18

	port_match u_dport
	(
		.mode  (dport_mode_q),
		.lo    (dport_bound_q[15:0]),
		.hi    (dport_bound_q[31:16]),
		.port  (frame_dport),
		.match (dport_ok)
	); // see R5, R6, R18

	// Flag order FIN, SYN, RST, PSH, ACK, URG from bit 0
	flag_match #(.NFLAGS(6)) u_flags
	(
		.setting (flags_q),
		.flags   (frame_tcp_flags),
		.match   (flags_ok)
	); // see R7, R8, R9, R10, R11, R12

	// Flags mean nothing on non-TCP frames, so they only gate TCP traffic
	wire l4_ok    = ~l4_sel | (sport_ok & dport_ok &
	                (~(proto_sel == `PROTO_TCP) | ~frame_is_tcp | flags_ok)); // see R17
	wire etype_ok = (ftype_sel != `FTYPE_ETYPE) | ~etype_q[`ETYPE_SPEC_BIT] |
	                (frame_ethtype == etype_q[15:0]); // see R13, R14, R15
	wire hit_d    = entry_en & l4_ok & etype_ok;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			hit_valid <= 1'b0;
			hit       <= 1'b0;
		end
		else
		begin
			hit_valid <= hdr_valid; // see R19
			if (hdr_valid)
				hit <= hit_d; // see R19
		end
	end

	// Hit counter saturates so software never sees a wrap
	wire cnt_clr = we_status & pwdata[`STAT_HIT_BIT];

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			hit_cnt_q <= {CNT_W{1'b0}};
		else if (hdr_valid & hit_d & ~(&hit_cnt_q))
			hit_cnt_q <= hit_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
		else if (cnt_clr)
			hit_cnt_q <= {CNT_W{1'b0}};
	end

endmodule
`default_nettype wire

// ### src/flag_match.v
// Three-valued TCP control flag criteria, one per flag bit
`timescale 1ns/1ps
`default_nettype none
`include "acl_l4_defines.vh"

module flag_match
#(
	parameter NFLAGS = 6
)
(
	// Two setting bits per flag, flag 0 lowest
	input  wire [2*NFLAGS-1:0] setting,
	// Flags of the frame
	input  wire [NFLAGS-1:0]   flags,
	// Result
	output wire                match
);

	wire [NFLAGS-1:0] ok;

	genvar i;
	generate
		for (i = 0; i < NFLAGS; i = i + 1)
		begin : g_flag
			wire [1:0] s = setting[2*i+1:2*i];
			// Codes above set count as don't-care
			assign ok[i] = (s == `FSET_CLEAR) ? ~flags[i] :
			               (s == `FSET_SET)   ?  flags[i] : 1'b1;
		end
	endgenerate

	assign match = &ok;

endmodule
`default_nettype wire

// ### src/port_match.v
// One transport-port criterion: don't-care, single value or inclusive range
`timescale 1ns/1ps
`default_nettype none
`include "acl_l4_defines.vh"

module port_match
(
	// Criterion setup
	input  wire [1:0]  mode,
	input  wire [15:0] lo,
	input  wire [15:0] hi,
	// Frame field
	input  wire [15:0] port,
	// Result
	output reg         match
);

	always @*
	begin
		case (mode)
			`PMODE_SINGLE: match = (port == lo);
			// Inverted bounds give an empty range, so never a hit
			`PMODE_RANGE:  match = (port >= lo) && (port <= hi) && (lo <= hi);
			default:       match = 1'b1;
		endcase
	end

endmodule
`default_nettype wire
